// >>> core/lcd_ext_cfg.sv
// Extended-page instruction decoder, scan mapping and icon blink for a
// character LCD driver, reached as an APB slave.
// Assumes scan_step and col_in are synchronous to mclk; answers have one
// cycle of latency.
// Function
// - Page instructions decoded only with page select
// - Split bit 0 pairs columns directly
// - Split bit 1 pairs columns in reverse
// - Column flip reverses column order 80..1
// - Two-line row order and icon rows flip
// - Single-line rows 1..8 flip, icon row 17
// - Icon mode 0 drives characters, mux 18/9
// - Icon mode 1 drives icons only, mux 2
// - Two voltage factors, chosen by icon mode
// - Icon blink independent of cursor blink
// - Blink off takes icons from characters 0-3
// - Blink on alternates characters 0-3 and 4-7
// - Blink off frees characters 4-7 for text
// - Cursor blink: block even, character odd
// - Blink period is oscillator over 52224
// - Glyph bit one lights its icon
// - Direct off leaves supply choice to system
// - Direct on stops generator, ties supply through
module lcd_ext_cfg
#(
  parameter int BLINK_DIV = lcd_ext_pkg::BLINK_DIV_DEF
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Scan request
  input wire logic [4:0] scan_step,
  input wire logic [7:0] col_in,
  // Scan answer and display state
  output lcd_ext_pkg::scan_s scan_o,
  output lcd_ext_pkg::supply_s supply_o,
  output logic cursor_block,
  output logic user_chars_hi
);

  // Half phase length; the counter toggles the phase at its end
  localparam logic [15:0] HALF_M1 = 16'(BLINK_DIV / 2 - 1);

  // Whole module state
  typedef struct packed
  {
    logic [7:0] last_cmd;
    lcd_ext_pkg::cfg_s cfg;
    lcd_ext_pkg::ctrl_s ctrl;
    logic last_ignored;
    logic [5:0] vf_char;
    logic [5:0] vf_icon;
    logic [5:0] gaddr;
    logic [63:0][4:0] glyph;
    logic [15:0] blink_cnt;
    logic odd;
    lcd_ext_pkg::scan_s scan;
    lcd_ext_pkg::supply_s supply;
    logic cursor_block;
    logic user_hi;
  } st_s;

  st_s q; // Registered state
  st_s d; // Next state

  logic wr; // Write access phase
  logic cmd_wr; // Write to command word
  logic cmd_exec; // Command is an instruction-register write
  logic [6:0] col_k; // Column inside its half
  logic [6:0] col_f; // After column flip
  logic [6:0] col_m; // After split pairing
  logic [4:0] row_f; // Character row index after row flip
  logic [4:0] nchar; // Character rows in use
  logic [5:0] gbase; // First glyph row for the icon row in scan
  lcd_ext_pkg::stat_s stat; // Status view
  logic mapped; // Address hits a register

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign cmd_wr = wr & (paddr == lcd_ext_pkg::OFS_CMD);
  assign cmd_exec = cmd_wr & ~pwdata[lcd_ext_pkg::CMD_REGSEL_BIT]
    & ~pwdata[lcd_ext_pkg::CMD_RD_BIT];
  assign nchar = q.ctrl.single_line_select ? lcd_ext_pkg::ROWS_ONE
    : lcd_ext_pkg::ROWS_TWO;

  // Column inside its half; the second half starts at logical 81
  assign col_k = (col_in >= 8'(lcd_ext_pkg::HALF_COLS))
    ? 7'(col_in - 8'(lcd_ext_pkg::HALF_COLS)) : col_in[6:0];

  // Column flip within each half
  index_flip #(.W(7)) u_col_flip
  (
    .flip(q.cfg.col_flip),
    .span(lcd_ext_pkg::HALF_COLS),
    .idx(col_k),
    .out(col_f)
  );

  // Mirrored pairing walks the second half backwards
  index_flip #(.W(7)) u_col_pair
  (
    .flip(q.cfg.split_mirror),
    .span(lcd_ext_pkg::HALF_COLS),
    .idx(col_f),
    .out(col_m)
  );

  // Row flip over the character rows in use
  index_flip #(.W(5)) u_row_flip
  (
    .flip(q.cfg.row_flip),
    .span(nchar),
    .idx(scan_step),
    .out(row_f)
  );

  // Status view for reads
  always_comb
  begin
    stat.cfg = q.cfg;
    stat.odd_phase = q.odd;
    stat.last_ignored = q.last_ignored;
    stat.mux = q.supply.mux;
  end

  // Register read mux; unmapped addresses read zero and flag an error
  always_comb
  begin
    prdata = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      lcd_ext_pkg::OFS_CMD: prdata = {24'h00_0000, q.last_cmd};
      lcd_ext_pkg::OFS_CTRL: prdata = 32'(q.ctrl);
      lcd_ext_pkg::OFS_STAT: prdata = 32'(stat);
      lcd_ext_pkg::OFS_VFAC: prdata = {18'h0_0000, q.vf_icon, 2'h0, q.vf_char};
      lcd_ext_pkg::OFS_GADR: prdata = {26'h000_0000, q.gaddr};
      lcd_ext_pkg::OFS_GDAT: prdata = {27'h000_0000, q.glyph[q.gaddr]};
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~mapped;

  // Next-state logic: registers, decoder, blink timer and scan mapping
  always_comb
  begin
    d = q;
    gbase = 6'h00;

    // Software register writes
    if (wr)
    begin
      case (paddr)
        lcd_ext_pkg::OFS_CTRL: d.ctrl = pwdata[3:0];
        lcd_ext_pkg::OFS_VFAC:
        begin
          d.vf_char = pwdata[5:0];
          d.vf_icon = pwdata[lcd_ext_pkg::VF_ICON_LSB +: 6];
        end
        lcd_ext_pkg::OFS_GADR: d.gaddr = pwdata[5:0];
        lcd_ext_pkg::OFS_GDAT: d.glyph[q.gaddr] = pwdata[4:0];
        default: ;
      endcase
    end

    // Instruction decode; anything else on this page is left alone
    if (cmd_wr)
    begin
      d.last_cmd = pwdata[7:0];
      d.last_ignored = 1'b1;
      if (cmd_exec && q.ctrl.page_select)
      begin
        if (pwdata[7:1] == lcd_ext_pkg::OP_SCREEN)
        begin
          d.cfg.split_mirror = pwdata[0];
          d.last_ignored = 1'b0;
        end
        else if (pwdata[7:2] == lcd_ext_pkg::OP_DISP)
        begin
          d.cfg.col_flip = pwdata[1];
          d.cfg.row_flip = pwdata[0];
          d.last_ignored = 1'b0;
        end
        else if (pwdata[7:3] == lcd_ext_pkg::OP_ICON)
        begin
          d.cfg.icon_only_select = pwdata[2];
          d.cfg.icon_blink_enable = pwdata[1];
          d.cfg.direct_supply_select = pwdata[0];
          d.last_ignored = 1'b0;
        end
      end
    end

    // Free-running half-phase timer shared by both blink functions
    if (q.blink_cnt == HALF_M1)
    begin
      d.blink_cnt = 16'h0000;
      d.odd = ~q.odd;
    end
    else
    begin
      d.blink_cnt = q.blink_cnt + 16'h0001;
    end

    // Row for this scan step
    d.scan.row_valid = 1'b1;
    d.scan.row_num = 5'h00;
    if (q.cfg.icon_only_select)
    begin
      // Icons only: two steps with two lines, one step with one line, icon rows in flip order
      if (scan_step == 5'h00)
        d.scan.row_num = (q.cfg.row_flip && !q.ctrl.single_line_select)
          ? lcd_ext_pkg::ICON_ROW_B : lcd_ext_pkg::ICON_ROW_A;
      else if (scan_step == 5'h01 && !q.ctrl.single_line_select)
        d.scan.row_num = q.cfg.row_flip ? lcd_ext_pkg::ICON_ROW_A
          : lcd_ext_pkg::ICON_ROW_B;
      else
        d.scan.row_valid = 1'b0;
    end
    else if (scan_step < nchar)
      d.scan.row_num = row_f + 5'h01;
    else if (scan_step == nchar)
      d.scan.row_num = (q.cfg.row_flip && !q.ctrl.single_line_select)
        ? lcd_ext_pkg::ICON_ROW_B : lcd_ext_pkg::ICON_ROW_A;
    else if (scan_step == nchar + 5'h01 && !q.ctrl.single_line_select)
      d.scan.row_num = q.cfg.row_flip ? lcd_ext_pkg::ICON_ROW_A
        : lcd_ext_pkg::ICON_ROW_B;
    else
      d.scan.row_valid = 1'b0;

    // Physical column: first half as flipped, second half paired
    d.scan.col_num = (col_in >= 8'(lcd_ext_pkg::HALF_COLS))
      ? 8'(lcd_ext_pkg::HALF_COLS) + {1'b0, col_m}
      : {1'b0, col_f};

    // Icon bank: odd blink phase reads characters 4 to 7
    if (q.cfg.icon_blink_enable && q.odd)
      gbase = lcd_ext_pkg::GRAM_ODD_BASE;
    if (d.scan.row_num == lcd_ext_pkg::ICON_ROW_B)
      gbase = gbase + lcd_ext_pkg::GRAM_ROWB_OFS;

    // Five icons per glyph row, leftmost icon in the top bit
    for (int i = 0; i < lcd_ext_pkg::ICONS_PER_ROW; i++)
    begin
      d.scan.icon_bits[i] = q.glyph[gbase + 6'(i / 5)][3'(4 - i % 5)]
        & d.scan.row_valid & d.scan.row_num[4];
    end

    // Supply steering from the mode bits
    d.supply.vfactor = q.cfg.icon_only_select ? q.vf_icon
      : q.vf_char;
    d.supply.direct_connect = q.cfg.direct_supply_select;
    d.supply.gen_on = ~q.cfg.direct_supply_select
      & ~q.ctrl.ext_supply;
    if (q.cfg.icon_only_select)
      d.supply.mux = lcd_ext_pkg::MUX_2;
    else if (q.ctrl.single_line_select)
      d.supply.mux = lcd_ext_pkg::MUX_9;
    else
      d.supply.mux = lcd_ext_pkg::MUX_18;

    // Cursor blink shows a full block in the even phase only
    d.cursor_block = q.ctrl.char_blink & ~q.odd;
    // Upper user glyphs are free while icons do not blink
    d.user_hi = ~q.cfg.icon_blink_enable;
  end

  // State register; reset gives every mode its off value
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '0;
    else
      q <= d;
  end

  // Registered outputs
  assign scan_o = q.scan;
  assign supply_o = q.supply;
  assign cursor_block = q.cursor_block;
  assign user_chars_hi = q.user_hi;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // Instructions without page select leave the modes alone
  page_gate_a: assert property ((cmd_wr && !q.ctrl.page_select) |=>
    (q.cfg == $past(q.cfg))) else $error("mode changed off page");

  // Screen instruction stores its split bit
  split_store_a: assert property ((cmd_exec && q.ctrl.page_select &&
    pwdata[7:1] == lcd_ext_pkg::OP_SCREEN) |=>
    (q.cfg.split_mirror == $past(pwdata[0])))
    else $error("split bit not stored");

  // Mirrored pairing sends logical 81 to column 160
  pair_mirror_a: assert property ((col_in == 8'h50 &&
    q.cfg.split_mirror && !q.cfg.col_flip) |=> (scan_o.col_num == 8'h9F))
    else $error("mirrored pair wrong");

  // Column flip sends the first column to column 80
  col_flip_a: assert property ((col_in == 8'h00 && q.cfg.col_flip) |=>
    (scan_o.col_num == 8'h4F)) else $error("column flip wrong");

  // Flipped two-line scan starts at row 16
  row_flip_a: assert property ((scan_step == 5'h00 && q.cfg.row_flip &&
    !q.ctrl.single_line_select && !q.cfg.icon_only_select) |=>
    (scan_o.row_num == 5'h10)) else $error("row flip wrong");

  // Single line keeps its icon row at 17
  single_icon_a: assert property ((scan_step == 5'h08 &&
    q.ctrl.single_line_select && !q.cfg.icon_only_select) |=>
    (scan_o.row_num == 5'h11)) else $error("single line icon row");

  // Entering icon mode selects the icon voltage factor
  vf_select_a: assert property ($rose(q.cfg.icon_only_select) |=>
    (supply_o.vfactor == $past(q.vf_icon) &&
    supply_o.mux == lcd_ext_pkg::MUX_2)) else $error("icon factor wrong");

  // Phase turns only after a full half period
  blink_rate_a: assert property ($changed(q.odd) |->
    ($past(q.blink_cnt) == HALF_M1 && q.blink_cnt == 16'h0000))
    else $error("blink phase early");

  // Even phase with cursor blink shows the block
  cursor_blk_a: assert property ((q.ctrl.char_blink && !q.odd) |=>
    cursor_block) else $error("cursor block missing");

  // Direct mode stops the generator and ties supply through
  direct_mode_a: assert property (q.cfg.direct_supply_select |=>
    (!supply_o.gen_on && supply_o.direct_connect))
    else $error("direct mode wrong");

endmodule : lcd_ext_cfg

// >>> core/lcd_ext_pkg.sv
// Constants, layouts and carrier types for the extended display-config block.
// Assumes a 50 MHz mclk and an APB master with 32-bit data.
package lcd_ext_pkg;

  // APB byte offsets, one aligned word each
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_VFAC = 8'h0C;
  localparam logic [7:0] OFS_GADR = 8'h10;
  localparam logic [7:0] OFS_GDAT = 8'h14;

  // Command word fields: instruction byte in [7:0]
  localparam int CMD_REGSEL_BIT = 8;
  localparam int CMD_RD_BIT = 9;
  localparam int VF_ICON_LSB = 8;

  // Fixed upper bits of the three page instructions
  localparam logic [6:0] OP_SCREEN = 7'h01;
  localparam logic [5:0] OP_DISP = 6'h01;
  localparam logic [4:0] OP_ICON = 5'h01;

  // Row numbering (one-based, as on the glass)
  localparam logic [4:0] ROWS_TWO = 5'h10;
  localparam logic [4:0] ROWS_ONE = 5'h08;
  localparam logic [4:0] ICON_ROW_A = 5'h11;
  localparam logic [4:0] ICON_ROW_B = 5'h12;

  // Columns per half screen and glyph RAM layout
  localparam logic [6:0] HALF_COLS = 7'h50;
  localparam logic [5:0] GRAM_ODD_BASE = 6'h20;
  localparam logic [5:0] GRAM_ROWB_OFS = 6'h10;
  localparam int ICONS_PER_ROW = 80;

  // Oscillator cycles per full blink period
  localparam int BLINK_DIV_DEF = 52224;

  // Multiplex ratio codes
  typedef enum logic [1:0]
  {
    MUX_18 = 2'b00,
    MUX_9 = 2'b01,
    MUX_2 = 2'b10
  } mux_e;

  // Decoded page configuration
  typedef struct packed
  {
    logic split_mirror;
    logic col_flip;
    logic row_flip;
    logic icon_only_select;
    logic icon_blink_enable;
    logic direct_supply_select;
  } cfg_s;

  // Control register, MSB first down to bit 0
  typedef struct packed
  {
    logic ext_supply;
    logic char_blink;
    logic single_line_select;
    logic page_select;
  } ctrl_s;

  // Status register, MSB first down to bit 0
  typedef struct packed
  {
    mux_e mux;
    logic last_ignored;
    logic odd_phase;
    cfg_s cfg;
  } stat_s;

  // Row/column/icon data for one scan step
  typedef struct packed
  {
    logic row_valid;
    logic [4:0] row_num;
    logic [7:0] col_num;
    logic [ICONS_PER_ROW-1:0] icon_bits;
  } scan_s;

  // Display supply steering
  typedef struct packed
  {
    logic gen_on;
    logic direct_connect;
    logic [5:0] vfactor;
    mux_e mux;
  } supply_s;

endpackage : lcd_ext_pkg

// >>> core/index_flip.sv
// Mirrors an index inside a span when flip is set.
// Purely combinational; span must be at least one.
module index_flip
#(
  parameter int W = 7
)
(
  // Control
  input wire logic flip,
  input wire logic [W-1:0] span,
  // Index in and out
  input wire logic [W-1:0] idx,
  output logic [W-1:0] out
);

  // Reverse order counts down from span-1
  always_comb
  begin
    out = flip ? W'(span - idx - 1'b1) : idx;
  end

endmodule : index_flip

// >>> sim/host_model.sv
// APB master that stands in for the host microcontroller.
// Assumes one bench process calls xfer at a time.
module host_model
(
  // Clock
  input wire logic mclk,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One transfer; no latency is assumed, the bench timeout ends a hang
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic er);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data shows the inverse so a stale value cannot pass
    pwdata <= ~d;
  endtask : xfer
endmodule : host_model

// >>> sim/testbench.sv
// Self-checking bench for the extended display-config block.
// Assumes host_model as APB master and a shortened blink divider.
`define CHK(n, e, g) \
  begin \
    cmp_count++; \
    if ((e) !== (g)) \
    begin \
      errors++; \
      $display("unexpected %s: expected %0h seen %0h", n, e, g); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // Short blink period keeps the run brief
  localparam int DIV = 8;
  logic mclk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, col_in, cmd;
  logic [31:0] pwdata, prdata, rd, r;
  logic [31:0] seed = 32'hF905A292;
  logic [4:0] scan_step;
  lcd_ext_pkg::scan_s scan_o;
  lcd_ext_pkg::supply_s supply_o;
  lcd_ext_pkg::cfg_s cfg;
  logic cursor_block, user_chars_hi, err, one_line, ext, pg, reg_sel, ok;
  logic [5:0] vc, vi;
  int errors, cmp_count, cnt_b, cnt_o;

  lcd_ext_cfg #(.BLINK_DIV(DIV)) i_lcd_ext_cfg (.mclk(mclk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scan_step(scan_step), .col_in(col_in), .scan_o(scan_o),
    .supply_o(supply_o), .cursor_block(cursor_block),
    .user_chars_hi(user_chars_hi));
  host_model i_host_model (.mclk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Fixed-seed xorshift
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Whether a byte is one of the three page instructions
  function automatic logic known(logic [7:0] b);
    return b[7:1] == 7'h01 || b[7:2] == 6'h01 || b[7:3] == 5'h01;
  endfunction : known
  // Mode state after an accepted instruction
  function automatic lcd_ext_pkg::cfg_s nxt(lcd_ext_pkg::cfg_s c,
    logic [7:0] b);
    if (b[7:1] == 7'h01)
      c.split_mirror = b[0];
    else if (b[7:2] == 6'h01)
      {c.col_flip, c.row_flip} = b[1:0];
    else if (b[7:3] == 5'h01)
      {c.icon_only_select, c.icon_blink_enable,
        c.direct_supply_select} = b[2:0];
    return c;
  endfunction : nxt
  // Icon i of a glyph row takes bit 4-i
  function automatic logic [4:0] rev5(logic [4:0] d);
    return {d[0], d[1], d[2], d[3], d[4]};
  endfunction : rev5
  // Physical row for a scan step
  function automatic logic [4:0] erow(logic [4:0] s, logic q, logic one);
    if (one)
      return s < 5'h08 ? (q ? 5'h08 - s : s + 5'h01) : 5'h11;
    if (s < 5'h10)
      return q ? 5'h10 - s : s + 5'h01;
    return (s == 5'h10) ^ q ? 5'h11 : 5'h12;
  endfunction : erow
  // Physical column for a logical column
  function automatic logic [7:0] ecol(logic [7:0] k, logic p, logic l);
    logic [7:0] b;
    b = k < 8'h50 ? k : k - 8'h50;
    b = p ? 8'h4F - b : b;
    return k < 8'h50 ? b : 8'h50 + (l ? 8'h4F - b : b);
  endfunction : ecol

  // Bus wrappers
  task automatic wr(logic [7:0] a, logic [31:0] d);
    i_host_model.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdx(logic [7:0] a);
    i_host_model.xfer(1'b0, a, 32'h0, rd, err);
  endtask : rdx
  // Present a scan request and wait for its registered answer
  task automatic sc(logic [4:0] s, logic [7:0] k);
    @(posedge mclk);
    scan_step <= s;
    col_in <= k;
    @(posedge mclk);
    @(negedge mclk);
  endtask : sc

  // Verdict and end of run
  task automatic final_report();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  // Clock at 50 MHz
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #400000;
    errors++;
    final_report();
  end

  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    scan_step = 5'h00;
    col_in = 8'h00;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    `CHK("mux", lcd_ext_pkg::MUX_18, supply_o.mux)
    `CHK("user_chars_hi", 1'b1, user_chars_hi)
    // Unmapped place is refused
    rdx(8'h3C);
    `CHK("pslverr", 1'b1, err)
    `CHK("prdata", 32'h0, rd)
    r = rnd();
    vc = r[5:0];
    vi = r[13:8];
    wr(lcd_ext_pkg::OFS_VFAC, {18'h0, vi, 2'h0, vc});
    rdx(lcd_ext_pkg::OFS_VFAC);
    `CHK("vfac", {vi, 2'h0, vc}, rd[13:0])
    // Random instructions, page select mostly on
    cfg = '0;
    for (int i = 0; i < 48; i++)
    begin
      r = rnd();
      {ext, one_line} = r[3:2];
      pg = r[0] | r[1];
      reg_sel = r[7:4] == 4'h0;
      case (r[9:8])
        2'h0: cmd = {7'h01, r[10]};
        2'h1: cmd = {6'h01, r[11:10]};
        2'h2: cmd = {5'h01, r[12:10]};
        default: cmd = r[23:16];
      endcase
      wr(lcd_ext_pkg::OFS_CTRL, {28'h0, ext, 1'b0, one_line, pg});
      wr(lcd_ext_pkg::OFS_CMD, {23'h0, reg_sel, cmd});
      ok = pg & !reg_sel & known(cmd);
      cfg = ok ? nxt(cfg, cmd) : cfg;
      rdx(lcd_ext_pkg::OFS_STAT);
      `CHK("cfg", cfg, rd[5:0])
      `CHK("ignored", !ok, rd[7])
      `CHK("mux", cfg.icon_only_select ? lcd_ext_pkg::MUX_2 : one_line ?
        lcd_ext_pkg::MUX_9 : lcd_ext_pkg::MUX_18, supply_o.mux)
      `CHK("vfactor", cfg.icon_only_select ? vi : vc, supply_o.vfactor)
      `CHK("gen_on", !cfg.direct_supply_select & !ext, supply_o.gen_on)
      `CHK("direct", cfg.direct_supply_select, supply_o.direct_connect)
      `CHK("user_chars", !cfg.icon_blink_enable, user_chars_hi)
    end
    // Every split and flip combination, two lines then one
    // Page on first, else the character mode instruction is dropped
    wr(lcd_ext_pkg::OFS_CTRL, 32'h1);
    wr(lcd_ext_pkg::OFS_CMD, 32'h08);
    for (int m = 0; m < 16; m++)
    begin
      wr(lcd_ext_pkg::OFS_CTRL, {30'h0, m[3], 1'b1});
      wr(lcd_ext_pkg::OFS_CMD, {24'h0, 7'h01, m[2]});
      wr(lcd_ext_pkg::OFS_CMD, {24'h0, 6'h01, m[1:0]});
      for (int s = 0; s < 18; s++)
      begin
        // First two steps pin both half-screen edges, then random columns
        r = s < 2 ? 32'(s * 80) : rnd() % 160;
        sc(s[4:0], r[7:0]);
        if (m[3] && s > 8)
          `CHK("row_valid", 1'b0, scan_o.row_valid)
        else
        begin
          `CHK("row", erow(s[4:0], m[0], m[3]), scan_o.row_num)
          `CHK("col", ecol(r[7:0], m[1], m[2]), scan_o.col_num)
        end
      end
    end
    // Glyph rows for both icon rows and the odd bank
    wr(lcd_ext_pkg::OFS_CTRL, 32'h1);
    wr(lcd_ext_pkg::OFS_CMD, 32'h04);
    wr(lcd_ext_pkg::OFS_GADR, 32'h00);
    // Uneven patterns, so a reversed bit order cannot slip through
    wr(lcd_ext_pkg::OFS_GDAT, 32'h18);
    wr(lcd_ext_pkg::OFS_GADR, 32'h10);
    wr(lcd_ext_pkg::OFS_GDAT, 32'h13);
    wr(lcd_ext_pkg::OFS_GADR, 32'h20);
    wr(lcd_ext_pkg::OFS_GDAT, 32'h06);
    rdx(lcd_ext_pkg::OFS_GDAT);
    `CHK("gdat", 32'h06, rd)
    sc(5'h10, 8'h00);
    `CHK("icons17", rev5(5'h18), scan_o.icon_bits[4:0])
    sc(5'h11, 8'h00);
    `CHK("icons18", rev5(5'h13), scan_o.icon_bits[4:0])
    // Icons only: first step carries icon row 17, steps after the second are dark
    wr(lcd_ext_pkg::OFS_CMD, 32'h0C);
    sc(5'h00, 8'h00);
    `CHK("icon_row", 5'h11, scan_o.row_num)
    `CHK("icon_bits", rev5(5'h18), scan_o.icon_bits[4:0])
    sc(5'h02, 8'h00);
    `CHK("icon_off", 81'h0, {scan_o.row_valid, scan_o.icon_bits})
    // Cursor blink and icon blink each on alone and together
    for (int j = 1; j < 4; j++)
    begin
      wr(lcd_ext_pkg::OFS_CTRL, {29'h0, j[0], 2'h1});
      wr(lcd_ext_pkg::OFS_CMD, {24'h0, 5'h01, 1'b0, j[1], 1'b0});
      sc(5'h10, 8'h00);
      cnt_b = 0;
      cnt_o = 0;
      for (int c = 0; c < 2 * DIV; c++)
      begin
        @(negedge mclk);
        cnt_o += scan_o.icon_bits[4:0] === rev5(5'h06);
        cnt_b += cursor_block === 1'b1;
      end
      `CHK("odd_icons", j[1] ? DIV : 0, cnt_o)
      `CHK("block", j[0] ? DIV : 0, cnt_b)
    end
    // Host leaves the page; page instructions no longer act
    wr(lcd_ext_pkg::OFS_CTRL, 32'h0);
    wr(lcd_ext_pkg::OFS_CMD, 32'h0F);
    rdx(lcd_ext_pkg::OFS_STAT);
    `CHK("ignored", 1'b1, rd[7])
    `CHK("icon_mode", 1'b0, rd[2])
    final_report();
  end
endmodule : testbench
